// [rtl/mxemp_addr_route.sv]
// effective address and on/off-chip routing decision
`timescale 1ns/1ns
`default_nettype none
module mxemp_addr_route
  import mxemp_pkg::*;
(
  input  wire logic                    wide_i,
  input  wire logic [ADDR_W-1:0]       data_pointer_i,
  input  wire logic [7:0]              low_reg_i,
  input  wire logic [PAGE_W-1:0]       page_i,
  input  wire logic [1:0]              mode_i,
  input  wire logic [ADDR_W-1:0]       onchip_top_i,
  output logic      [ADDR_W-1:0]       eff_addr_o,
  output logic      [ADDR_W-1:0]       onchip_addr_o,
  output logic                         off_chip_o,
  output logic                         drive_upper_o
);
  logic [ADDR_W-1:0] eff;
  logic              below;

  always_comb begin
    // pointer or page plus low reg
    eff = wide_i ? data_pointer_i : {page_i, low_reg_i};
    below = (eff < onchip_top_i);
    off_chip_o    = 1'b0;
    drive_upper_o = 1'b0;
    case (mode_i)
      MODE_INT_ONLY: begin
        off_chip_o = 1'b0;
      end
      MODE_SPLIT_NOBS, MODE_SPLIT_BS: begin
        off_chip_o = ~below;
        drive_upper_o = wide_i | (mode_i == MODE_SPLIT_BS);
      end
      MODE_EXT_ONLY: begin
        off_chip_o = 1'b1;
        drive_upper_o = wide_i;
      end
      default: begin
        off_chip_o = 1'b0;
      end
    endcase
  end

  assign eff_addr_o = (mode_i == MODE_EXT_ONLY && !wide_i) ? {8'h00, low_reg_i} : eff;
  assign onchip_addr_o = (onchip_top_i != '0) ? (eff % onchip_top_i) : eff;
endmodule : mxemp_addr_route
`default_nettype wire

// [rtl/mxemp_cfg_regs.sv]
// configuration holding registers for the memory port
`timescale 1ns/1ns
`default_nettype none
module mxemp_cfg_regs
  import mxemp_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    cfg_we_i,
  input  wire logic [1:0]              memory_mode_field_i,
  input  wire logic [1:0]              latch_width_field_i,
  input  wire logic [3:0]              strobe_width_field_i,
  input  wire logic [1:0]              setup_delay_field_i,
  input  wire logic [1:0]              hold_delay_field_i,
  input  wire logic                    page_we_i,
  input  wire logic [PAGE_W-1:0]       page_field_i,
  output logic      [1:0]              mode_o,
  output logic      [1:0]              latch_o,
  output logic      [3:0]              strobe_o,
  output logic      [1:0]              setup_o,
  output logic      [1:0]              hold_o,
  output logic      [PAGE_W-1:0]       page_o
);
  logic [1:0]        mode_q, mode_d, latch_q, latch_d, setup_q, setup_d, hold_q, hold_d;
  logic [3:0]        strobe_q, strobe_d;
  logic [PAGE_W-1:0] page_q, page_d;

  always_comb begin
    mode_d   = mode_q;
    latch_d  = latch_q;
    strobe_d = strobe_q;
    setup_d  = setup_q;
    hold_d   = hold_q;
    page_d   = page_q;
    if (cfg_we_i) begin
      mode_d   = memory_mode_field_i;
      latch_d  = latch_width_field_i;
      strobe_d = strobe_width_field_i;
      setup_d  = setup_delay_field_i;
      hold_d   = hold_delay_field_i;
    end
    if (page_we_i) begin
      page_d = page_field_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode_q   <= MODE_RST;
      latch_q  <= LATCH_RST;
      strobe_q <= STROBE_RST;
      setup_q  <= SETUP_RST;
      hold_q   <= HOLD_RST;
      page_q   <= PAGE_RST;
    end else begin
      mode_q   <= mode_d;
      latch_q  <= latch_d;
      strobe_q <= strobe_d;
      setup_q  <= setup_d;
      hold_q   <= hold_d;
      page_q   <= page_d;
    end
  end

  assign mode_o   = mode_q;
  assign latch_o  = latch_q;
  assign strobe_o = strobe_q;
  assign setup_o  = setup_q;
  assign hold_o   = hold_q;
  assign page_o   = page_q;
endmodule : mxemp_cfg_regs
`default_nettype wire

// [rtl/mxemp_pkg.sv]
// package of constants and types for the muxed external memory port
package mxemp_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned CNT_W  = 5;
  localparam logic [1:0] MODE_INT_ONLY   = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBS = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BS   = 2'h2;
  localparam logic [1:0] MODE_EXT_ONLY   = 2'h3;
  // reset values of timing and config fields
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [1:0] LATCH_RST  = 2'h3;
  localparam logic [3:0] STROBE_RST = 4'hf;
  localparam logic [1:0] SETUP_RST  = 2'h3;
  localparam logic [1:0] HOLD_RST   = 2'h3;
  localparam logic [7:0] PAGE_RST   = 8'h00;
  // fixed overhead cycles of an off-chip access
  localparam int unsigned FIXED_OVH = 4;
  localparam logic [CNT_W-1:0] OVH_CNT = CNT_W'(FIXED_OVH - 1);
  // default on-chip boundary (first off-chip address)
  localparam logic [ADDR_W-1:0] ONCHIP_TOP_RST = 16'h1000;

  typedef enum logic [6:0] {
    MXEMP_IDLE  = 7'h01,
    MXEMP_LHIGH = 7'h02,
    MXEMP_LLOW  = 7'h04,
    MXEMP_SETUP = 7'h08,
    MXEMP_STRB  = 7'h10,
    MXEMP_HOLD  = 7'h20,
    MXEMP_OVH   = 7'h40
  } mxemp_state_e;
endpackage : mxemp_pkg

// [rtl/mxemp_top.sv]
// muxed external memory port top: access sequencer and pin control
`timescale 1ns/1ns
`default_nettype none
module mxemp_top
  import mxemp_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    cfg_we_i,
  input  wire logic [1:0]              memory_mode_field_i,
  input  wire logic [1:0]              latch_width_field_i,
  input  wire logic [3:0]              strobe_width_field_i,
  input  wire logic [1:0]              setup_delay_field_i,
  input  wire logic [1:0]              hold_delay_field_i,
  input  wire logic                    page_we_i,
  input  wire logic [mxemp_pkg::PAGE_W-1:0] page_field_i,
  input  wire logic [mxemp_pkg::ADDR_W-1:0] onchip_top_i,
  input  wire logic                    req_i,
  input  wire logic                    we_i,
  input  wire logic                    wide_i,
  input  wire logic [mxemp_pkg::ADDR_W-1:0] data_pointer_i,
  input  wire logic [7:0]              low_reg_i,
  input  wire logic [mxemp_pkg::DATA_W-1:0] wdata_i,
  output logic                         busy_o,
  output logic                         done_o,
  output logic [mxemp_pkg::DATA_W-1:0] rdata_o,
  output logic                         onchip_req_o,
  output logic                         onchip_we_o,
  output logic [mxemp_pkg::ADDR_W-1:0] onchip_addr_o,
  output logic [mxemp_pkg::DATA_W-1:0] onchip_wdata_o,
  input  wire logic [mxemp_pkg::DATA_W-1:0] onchip_rdata_i,
  input  wire logic [mxemp_pkg::DATA_W-1:0] ad_i,
  output logic [mxemp_pkg::DATA_W-1:0] ad_o,
  output logic                         ad_own_o,
  output logic                         ad_drv_dis_o,
  output logic [7:0]                   upper_addr_bit_o,
  output logic                         upper_own_o,
  output logic                         addr_latch_strobe_o,
  output logic                         read_strobe_n_o,
  output logic                         write_strobe_n_o,
  output logic                         ctrl_own_o,
  output logic [1:0]                   mode_o
);
  import mxemp_pkg::*;

  logic [1:0]        mode, latch_w, setup_w, hold_w;
  logic [3:0]        strobe_w;
  logic [PAGE_W-1:0] page;
  logic [ADDR_W-1:0] eff_addr, wrap_addr;
  logic              off_chip, drive_upper;

  mxemp_cfg_regs u_cfg (
    .ref_clk_i            (ref_clk_i),
    .sys_rst_i            (sys_rst_i),
    .cfg_we_i             (cfg_we_i),
    .memory_mode_field_i  (memory_mode_field_i),
    .latch_width_field_i  (latch_width_field_i),
    .strobe_width_field_i (strobe_width_field_i),
    .setup_delay_field_i  (setup_delay_field_i),
    .hold_delay_field_i   (hold_delay_field_i),
    .page_we_i            (page_we_i),
    .page_field_i         (page_field_i),
    .mode_o               (mode),
    .latch_o              (latch_w),
    .strobe_o             (strobe_w),
    .setup_o              (setup_w),
    .hold_o               (hold_w),
    .page_o               (page)
  );

  mxemp_addr_route u_route (
    .wide_i         (wide_i),
    .data_pointer_i (data_pointer_i),
    .low_reg_i      (low_reg_i),
    .page_i         (page),
    .mode_i         (mode),
    .onchip_top_i   (onchip_top_i),
    .eff_addr_o     (eff_addr),
    .onchip_addr_o  (wrap_addr),
    .off_chip_o     (off_chip),
    .drive_upper_o  (drive_upper)
  );

  mxemp_state_e      st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic              we_q, we_d, up_q, up_d, done_q, done_d;

  // sequencer next state
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    we_d   = we_q;
    up_d   = up_q;
    done_d = 1'b0;
    case (st_q)
      MXEMP_IDLE: begin
        if (req_i && off_chip) begin
          addr_d = eff_addr;
          wdat_d = wdata_i;
          we_d   = we_i;
          up_d   = drive_upper;
          st_d   = MXEMP_LHIGH;
          cnt_d  = CNT_W'(latch_w);
        end else if (req_i) begin
          // on-chip access answered next cycle
          if (!we_i) begin
            rdat_d = onchip_rdata_i;
          end
          done_d = 1'b1;
        end
      end
      MXEMP_LHIGH: begin
        if (cnt_q == '0) begin
          st_d  = MXEMP_LLOW;
          cnt_d = CNT_W'(latch_w);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MXEMP_LLOW: begin
        if (cnt_q == '0) begin
          if (setup_w == '0) begin
            st_d  = MXEMP_STRB;
            cnt_d = CNT_W'(strobe_w);
          end else begin
            st_d  = MXEMP_SETUP;
            cnt_d = CNT_W'(setup_w - 2'h1);
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MXEMP_SETUP: begin
        if (cnt_q == '0) begin
          st_d  = MXEMP_STRB;
          cnt_d = CNT_W'(strobe_w);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MXEMP_STRB: begin
        if (cnt_q == '0) begin
          if (!we_q) begin
            rdat_d = ad_i;
          end
          if (hold_w == '0) begin
            st_d  = MXEMP_OVH;
            cnt_d = OVH_CNT;
          end else begin
            st_d  = MXEMP_HOLD;
            cnt_d = CNT_W'(hold_w - 2'h1);
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MXEMP_HOLD: begin
        if (cnt_q == '0) begin
          st_d  = MXEMP_OVH;
          cnt_d = OVH_CNT;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      MXEMP_OVH: begin
        if (cnt_q == '0) begin
          st_d   = MXEMP_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = MXEMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q   <= MXEMP_IDLE;
      cnt_q  <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      we_q   <= 1'b0;
      up_q   <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      we_q   <= we_d;
      up_q   <= up_d;
      done_q <= done_d;
    end
  end

  logic active, data_phase;
  assign active     = (st_q != MXEMP_IDLE);
  assign data_phase = (st_q == MXEMP_SETUP) || (st_q == MXEMP_STRB) || (st_q == MXEMP_HOLD);

  assign ctrl_own_o = active;
  assign busy_o     = active;
  assign done_o     = done_q;
  assign rdata_o    = rdat_q;
  assign mode_o     = mode;

  // on-chip side, wrapped address
  assign onchip_req_o   = req_i && !off_chip && (st_q == MXEMP_IDLE);
  assign onchip_we_o    = we_i;
  assign onchip_addr_o  = wrap_addr;
  assign onchip_wdata_o = wdata_i;

  // pin register: pins straight from flops, no decode glitch
  logic [DATA_W-1:0] ad_q, ad_d;
  logic              ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;

  always_comb begin
    // low address then data on shared pins
    if (st_d == MXEMP_LHIGH || st_d == MXEMP_LLOW) begin
      ad_d = addr_d[7:0];
    end else begin
      ad_d = wdat_d;
    end
    // latch strobe high in first phase
    ale_d  = (st_d == MXEMP_LHIGH);
    rd_n_d = !((st_d == MXEMP_STRB) && !we_d);
    wr_n_d = !((st_d == MXEMP_STRB) && we_d);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ad_q   <= '0;
      ale_q  <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      ad_q   <= ad_d;
      ale_q  <= ale_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
    end
  end

  assign ad_o         = ad_q;
  // drivers released on read data phase; drive mode stays with port config
  assign ad_own_o     = active;
  assign ad_drv_dis_o = active && !we_q && data_phase;

  assign upper_addr_bit_o = addr_q[15:8];
  assign upper_own_o      = active && up_q;

  assign addr_latch_strobe_o = ale_q;
  assign read_strobe_n_o     = rd_n_q;
  assign write_strobe_n_o    = wr_n_q;
endmodule : mxemp_top
`default_nettype wire

// [sim/mxemp_sram_model.sv]
// behavioural memory behind an address latch
`timescale 1ns/1ns
`default_nettype none
module mxemp_sram_model (
  input  wire logic [7:0]  bus_i,
  input  wire logic        clk_i,
  input  wire logic [7:0]  upper_i,
  input  wire logic        upper_own_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  output logic      [7:0]  bus_o,
  output logic      [15:0] addr_o
);
  logic [7:0] mem [0:255];
  logic [7:0] junk_q = 8'h55;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  always @(posedge clk_i) begin
    junk_q <= ~junk_q;
    // parked upper pins idle high
    if (ale_i) addr_o <= {upper_own_i ? upper_i : 8'hff, bus_i};
    if (!wr_n_i) mem[addr_o[7:0] ^ addr_o[15:8]] <= bus_i;
  end
  assign bus_o = !rd_n_i ? mem[addr_o[7:0] ^ addr_o[15:8]] : junk_q;
endmodule : mxemp_sram_model
`default_nettype wire

// [sim/mxemp_top_chk.sv]
// checker of the muxed external memory port
`timescale 1ns/1ns
`default_nettype none
module mxemp_top_chk
  import mxemp_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cfg_we_i,
  input wire logic [1:0] latch_width_field_i,
  input wire logic [3:0] strobe_width_field_i,
  input wire logic [1:0] setup_delay_field_i,
  input wire logic [1:0] hold_delay_field_i,
  input wire logic       req_i,
  input wire logic       wide_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic       onchip_req_o,
  input wire logic       ad_own_o,
  input wire logic       ad_drv_dis_o,
  input wire logic       upper_own_o,
  input wire logic       addr_latch_strobe_o,
  input wire logic       read_strobe_n_o,
  input wire logic       write_strobe_n_o,
  input wire logic       ctrl_own_o,
  input wire logic [1:0] mode_o
);
  logic [9:0] t_q, t_d;
  logic [7:0] bc_q, bc_d, ac_q, ac_d, sc_q, sc_d;
  logic       strb;
  assign strb = !read_strobe_n_o || !write_strobe_n_o;
  always_comb begin
    t_d = cfg_we_i ? {latch_width_field_i, setup_delay_field_i, strobe_width_field_i, hold_delay_field_i} : t_q;
    bc_d = busy_o ? bc_q + 8'h01 : 8'h00;
    ac_d = addr_latch_strobe_o ? ac_q + 8'h01 : 8'h00;
    sc_d = strb ? sc_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      t_q <= {LATCH_RST, SETUP_RST, STROBE_RST, HOLD_RST};
      {bc_q, ac_q, sc_q} <= 24'h000000;
    end else begin
      t_q <= t_d;
      {bc_q, ac_q, sc_q} <= {bc_d, ac_d, sc_d};
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  idle_release_a: assert property (!busy_o |-> !ad_own_o && !ctrl_own_o && !upper_own_o)
    else $error("pins owned while idle");
  read_release_a: assert property (!read_strobe_n_o |-> ad_drv_dis_o)
    else $error("driver on during read strobe");
  write_drive_a: assert property (!write_strobe_n_o |-> ad_own_o && !ad_drv_dis_o)
    else $error("write data not owning bus");
  latch_first_a: assert property ($rose(busy_o) |-> addr_latch_strobe_o && !strb)
    else $error("access not opened by latch phase");
  strobe_after_a: assert property (strb |-> !addr_latch_strobe_o && ctrl_own_o)
    else $error("strobe during latch phase");
  latch_width_a: assert property ($fell(addr_latch_strobe_o) |-> ac_q == t_q[9:8] + 1)
    else $error("latch high width wrong");
  strobe_width_a: assert property ($fell(strb) |-> sc_q == t_q[5:2] + 1)
    else $error("strobe width wrong");
  access_len_a: assert property ($fell(busy_o) |-> done_o && bc_q == 2 * (t_q[9:8] + 1) + t_q[7:6]
    + (t_q[5:2] + 1) + t_q[1:0] + FIXED_OVH)
    else $error("access length wrong");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  upper_drive_a: assert property ($rose(busy_o) |-> upper_own_o == ($past(wide_i) || mode_o == MODE_SPLIT_BS))
    else $error("upper pin ownership wrong");
  int_onchip_a: assert property (req_i && !busy_o && mode_o == MODE_INT_ONLY |-> onchip_req_o)
    else $error("internal mode went off-chip");
  ext_offchip_a: assert property (mode_o == MODE_EXT_ONLY |-> !onchip_req_o)
    else $error("external mode went on-chip");
  cover property ($fell(busy_o) && mode_o == MODE_SPLIT_BS);
  cover property ($fell(strb) && t_q[5:2] == 4'hf);
  cover property (onchip_req_o && mode_o == MODE_SPLIT_NOBS);
endmodule : mxemp_top_chk
bind mxemp_top mxemp_top_chk u_mxemp_top_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cfg_we_i(cfg_we_i),
  .latch_width_field_i(latch_width_field_i), .strobe_width_field_i(strobe_width_field_i),
  .setup_delay_field_i(setup_delay_field_i), .hold_delay_field_i(hold_delay_field_i),
  .req_i(req_i), .wide_i(wide_i), .busy_o(busy_o), .done_o(done_o), .onchip_req_o(onchip_req_o),
  .ad_own_o(ad_own_o), .ad_drv_dis_o(ad_drv_dis_o), .upper_own_o(upper_own_o),
  .addr_latch_strobe_o(addr_latch_strobe_o), .read_strobe_n_o(read_strobe_n_o),
  .write_strobe_n_o(write_strobe_n_o), .ctrl_own_o(ctrl_own_o), .mode_o(mode_o)
);
`default_nettype wire

// [sim/mxemp_top_tb_top.sv]
// testbench of the muxed external memory port
`timescale 1ns/1ns
`default_nettype none
module mxemp_top_tb_top;
  import mxemp_pkg::*;
  logic        clk = 0, rst = 1, cfg_we = 0, page_we = 0, req = 0, we = 0, wide = 0;
  logic [1:0]  mode = 0, lw = 0, su = 0, ho = 0, mode_q;
  logic [3:0]  pw = 0;
  logic [7:0]  page = 0, lo = 0, wd = 0, ordata = 0, rdata, ado, upper, ad_w, mdrv;
  logic [15:0] dp = 0, top = ONCHIP_TOP_RST, oaddr, maddr;
  logic        busy, done, oreq, own_ad, dis, uown, ale, rd_n, wr_n, owe, owe_s;
  logic [7:0]  owd, owd_s;
  int          mismatches = 0, num_checks = 0;
  always #2 clk = ~clk;
  assign ad_w = (own_ad && !dis) ? ado : mdrv;
  mxemp_top u_mxemp_top (.ref_clk_i(clk), .sys_rst_i(rst), .cfg_we_i(cfg_we), .memory_mode_field_i(mode),
    .latch_width_field_i(lw), .strobe_width_field_i(pw), .setup_delay_field_i(su), .hold_delay_field_i(ho),
    .page_we_i(page_we), .page_field_i(page), .onchip_top_i(top), .req_i(req), .we_i(we), .wide_i(wide),
    .data_pointer_i(dp), .low_reg_i(lo), .wdata_i(wd), .busy_o(busy), .done_o(done), .rdata_o(rdata),
    .onchip_req_o(oreq), .onchip_we_o(owe), .onchip_addr_o(oaddr), .onchip_wdata_o(owd), .onchip_rdata_i(ordata),
    .ad_i(ad_w), .ad_o(ado), .ad_own_o(own_ad), .ad_drv_dis_o(dis), .upper_addr_bit_o(upper),
    .upper_own_o(uown), .addr_latch_strobe_o(ale), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .ctrl_own_o(), .mode_o(mode_q));
  mxemp_sram_model u_mxemp_sram_model (.bus_i(ad_w), .clk_i(clk), .upper_i(upper), .upper_own_i(uown),
    .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .bus_o(mdrv), .addr_o(maddr));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cfg(input logic [1:0] m, l, s, h, input logic [3:0] p, input logic [7:0] pg);
    @(posedge clk) #1;
    {mode, lw, su, ho, pw, page, cfg_we, page_we} = {m, l, s, h, p, pg, 2'b11};
    @(posedge clk) #1;
    {cfg_we, page_we} = 2'b00;
  endtask : cfg
  task automatic acc(input logic w, wi, input logic [15:0] a, input logic [7:0] l, d,
                     output logic [7:0] rd, output int n, output logic q, output logic [15:0] oa);
    @(posedge clk) #1;
    {req, we, wide, dp, lo, wd, ordata} = {1'b1, w, wi, a, l, d, d};
    #1;
    q = oreq;
    oa = oaddr;
    {owe_s, owd_s} = {owe, owd};
    @(posedge clk) #1;
    req = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk) #1;
      n++;
    end
    chk("done_seen", 16'h1, {15'h0, done});
    rd = rdata;
  endtask : acc
  task automatic t_reset();
    chk("mode", {14'h0, MODE_RST}, {14'h0, mode_q});
    chk("busy", 16'h0, {15'h0, busy});
    chk("rdata", 16'h0, {8'h0, rdata});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_internal();
    logic [7:0] r;
    int n;
    logic q;
    logic [15:0] a;
    cfg(MODE_INT_ONLY, 2'h0, 2'h0, 2'h0, 4'h0, 8'h15);
    acc(1'b0, 1'b0, 16'h0, 8'h67, 8'ha5, r, n, q, a);
    chk("onchip_req", 16'h1, {15'h0, q});
    chk("onchip_addr", 16'h0567, a);
    chk("onchip_we", 16'h0, {15'h0, owe_s});
    chk("onchip_rdata", {8'h0, 8'ha5}, {8'h0, r});
    chk("onchip_cycles", 16'h1, 16'(n));
    acc(1'b1, 1'b1, 16'h1234, 8'h00, 8'h3c, r, n, q, a);
    chk("onchip_addr", 16'h0234, a);
    chk("onchip_we", 16'h1, {15'h0, owe_s});
    chk("onchip_wdata", 16'h003c, {8'h0, owd_s});
    $display("t_internal done");
  endtask : t_internal
  task automatic t_boundary();
    logic [7:0] r;
    int n;
    logic q;
    logic [15:0] a;
    cfg(MODE_SPLIT_NOBS, 2'h0, 2'h0, 2'h0, 4'h0, 8'h00);
    acc(1'b0, 1'b1, top - 16'h1, 8'h00, 8'h11, r, n, q, a);
    chk("below_onchip", 16'h1, {15'h0, q});
    acc(1'b0, 1'b1, top + 16'h1, 8'h00, 8'h11, r, n, q, a);
    chk("above_offchip", 16'h0, {15'h0, q});
    chk("min_cycles", 16'(2 + 1 + FIXED_OVH + 1), 16'(n));
    $display("t_boundary done");
  endtask : t_boundary
  task automatic t_modes();
    logic [7:0] r;
    int n, dur;
    logic q;
    logic [15:0] a, ea, dpv;
    for (int m = 1; m < 4; m++) begin
      cfg(2'(m), 2'(m), 2'(m), 2'(3 - m), 4'(m * 5), 8'h20);
      dur = 2 * (m + 1) + m + (m * 5 + 1) + (3 - m) + FIXED_OVH;
      ea = (m == 2) ? 16'h2040 : 16'hff40;
      dpv = (m == 3) ? 16'h0010 : 16'h3000;
      acc(1'b1, 1'b0, 16'h0, 8'h40, 8'h90 + 8'(m), r, n, q, a);
      chk("write_cycles", 16'(dur + 1), 16'(n));
      chk("ext_addr8", ea, maddr);
      acc(1'b0, 1'b0, 16'h0, 8'h40, 8'h00, r, n, q, a);
      chk("read8", {8'h0, 8'h90 + 8'(m)}, {8'h0, r});
      acc(1'b1, 1'b1, dpv, 8'h00, 8'hc0 + 8'(m), r, n, q, a);
      chk("ext_addr16", dpv, maddr);
      acc(1'b0, 1'b1, dpv, 8'h00, 8'h00, r, n, q, a);
      chk("read16", {8'h0, 8'hc0 + 8'(m)}, {8'h0, r});
      chk("offchip16", 16'h0, {15'h0, q});
    end
    $display("t_modes done");
  endtask : t_modes
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_internal();
    t_boundary();
    t_modes();
    end_of_test();
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule : mxemp_top_tb_top
`default_nettype wire
